// *** pkg/pm_wake_defines.vh ***
// Constants for the power-state, wake and fast target-access logic of a
// dual-function bus target. Included by bare name from the top-level rtl file only.
//
// Summary of operation
// - Serial channel accesses get at most one wait state on the bus.
// - A read of a serial channel finishes by the fifth bus clock.
// - A write to a serial channel finishes by the fourth bus clock.
// - Each function supports power states D0, D2 and D3 only, set by software.
// - Each function owns an independent power state and wake status.
// - Wake request is driven only while a function is in D2 or D3.
// - Serial function in D3 wakes only on ring indicator activity.
// - Serial function in D2 wakes on any modem input or receive data.
// - Parallel function wakes on activity of the two multi-purpose pins.
// - In low power, software may power down functions and disable ports.
// - Without configuration memory, built-in default identity and enables apply.
// - Configuration memory overrides identity and gates interrupts, power-down, wake.
// - Address phase then data phases share one 32-bit multiplexed bus.
`ifndef PM_WAKE_DEFINES_VH
`define PM_WAKE_DEFINES_VH

// ----------------------------------------------------------------------
// Power state encodings
// ----------------------------------------------------------------------
`define PM_D0 2'b00
`define PM_D1 2'b01
`define PM_D2 2'b10
`define PM_D3 2'b11

// ----------------------------------------------------------------------
// Function numbers
// ----------------------------------------------------------------------
`define FN_SERIAL 0
`define FN_PARALLEL 1

// ----------------------------------------------------------------------
// Bus commands (upper three bits; bit 0 is read/write)
// ----------------------------------------------------------------------
`define CMD_IO_RW 3'b001
`define CMD_MEM_RW 3'b011
`define CMD_WR_BIT 0

// ----------------------------------------------------------------------
// Default identity values (arbitrary, neutral) and default enables
// ----------------------------------------------------------------------
`define DEF_VENDOR_ID 16'h1234
`define DEF_DEVICE_ID 16'h0001
`define DEF_IRQ_EN 1'b1
`define DEF_PD_EN 1'b1
`define DEF_WAKE_EN 1'b1

`endif

// *** rtl/wake_event_detect.v ***
// Activity detector for a group of synchronous input lines.
// Assumes inputs already sampled on i_clk; any level change counts as activity.
`timescale 1ns/100ps
module wake_event_detect #(
	parameter WIDTH = 2
) (
	// Clock and reset
	input wire i_clk,
	input wire i_sys_rst,
	// Lines and gate
	input wire [WIDTH-1:0] i_lines,
	input wire i_arm,
	// Result
	output reg o_event
);

reg [WIDTH-1:0] prev_q;
wire [WIDTH-1:0] change;

// ----------------------------------------------------------------------
// Per-line change detect
// ----------------------------------------------------------------------
genvar g;
generate
	for (g = 0; g < WIDTH; g = g + 1) begin : g_line
		assign change[g] = i_lines[g] ^ prev_q[g];
	end
endgenerate

// History is kept while disarmed so entering low power never fires falsely
always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		prev_q <= {WIDTH{1'b0}};
		o_event <= 1'b0;
	end else begin
		prev_q <= i_lines;
		o_event <= i_arm & (|change);
	end
end

endmodule

// *** rtl/pci_power_state_wake_logic.v ***
// Power-state tracking, wake request and fast serial-channel target access.
// Assumes bus inputs synchronous to i_clk, address decode of the serial
// channel window done by comparison with a base parameter, one clock only.
`timescale 1ns/100ps
`include "pm_wake_defines.vh"
module pci_power_state_wake_logic #(
	parameter NCH = 2,
	parameter [31:0] UART_BASE = 32'h0000_0000,
	parameter [31:0] UART_MASK = 32'hFFFF_FFC0
) (
	// Clock and reset
	input wire i_clk,
	input wire i_sys_rst,
	// Bus target signals
	input wire i_frame_n,
	input wire i_irdy_n,
	input wire [31:0] i_ad,
	input wire [3:0] i_cbe_n,
	output reg [31:0] o_ad,
	output reg o_ad_oe,
	output reg o_devsel_n,
	output reg o_trdy_n,
	output reg o_stop_n,
	output reg o_tgt_oe,
	// Serial channel register port
	output reg o_uart_rd,
	output reg o_uart_wr,
	output reg [31:0] o_uart_addr,
	output reg [31:0] o_uart_wdata,
	output reg [3:0] o_uart_be_n,
	input wire [31:0] i_uart_rdata,
	// Power state control from configuration space
	input wire i_pm_wr,
	input wire i_pm_fn,
	input wire [1:0] i_pm_state,
	input wire [1:0] i_pme_en,
	input wire [1:0] i_pme_clr,
	output reg [3:0] o_pm_state,
	output reg [1:0] o_pme_status,
	// Wake sources
	input wire [NCH-1:0] i_ring_indicator_input,
	input wire [NCH-1:0] i_cts,
	input wire [NCH-1:0] i_dsr,
	input wire [NCH-1:0] i_dcd,
	input wire [NCH-1:0] i_rxd,
	input wire [1:0] i_multi_purpose_pins,
	// Wake request, open drain
	output reg o_pme_n,
	output reg o_pme_oe,
	// Power down controls from the driver
	input wire [1:0] i_pd_req,
	input wire i_uart_dis_req,
	input wire i_par_dis_req,
	output reg [1:0] o_func_pd,
	output reg o_uart_disable,
	output reg o_par_disable,
	// Configuration memory
	input wire i_eeprom_present,
	input wire i_eeprom_valid,
	input wire [15:0] i_eeprom_vendor_id,
	input wire [15:0] i_eeprom_device_id,
	input wire i_eeprom_irq_en,
	input wire i_eeprom_pd_en,
	input wire i_eeprom_wake_en,
	output reg [15:0] o_vendor_id,
	output reg [15:0] o_device_id,
	output reg o_irq_en
);

// ----------------------------------------------------------------------
// Target access sequencer
// ----------------------------------------------------------------------
localparam [2:0] S_IDLE = 3'b000;
localparam [2:0] S_WDATA = 3'b001;
localparam [2:0] S_RFETCH = 3'b010;
localparam [2:0] S_RDATA = 3'b011;
localparam [2:0] S_TURN = 3'b100;

reg [2:0] state_q;
reg frame_q;
wire cmd_ok;
wire addr_hit;
wire start;

// Address phase: frame newly low with a decodable command
assign cmd_ok = (i_cbe_n[3:1] == `CMD_IO_RW) | (i_cbe_n[3:1] == `CMD_MEM_RW);
assign addr_hit = ((i_ad & UART_MASK) == UART_BASE);
assign start = frame_q & ~i_frame_n & cmd_ok & addr_hit;

// Write: devsel and trdy in clock 2, data taken at clock 3 edge.
// Read: one wait state for the fetch, data at clock 4 edge.
// Only one data phase: stop goes with trdy, so bursts are disconnected
// rather than stretching the access beyond the bounded latency.
always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		state_q <= S_IDLE;
		frame_q <= 1'b1;
		o_ad <= 32'h0000_0000;
		o_ad_oe <= 1'b0;
		o_devsel_n <= 1'b1;
		o_trdy_n <= 1'b1;
		o_stop_n <= 1'b1;
		o_tgt_oe <= 1'b0;
		o_uart_rd <= 1'b0;
		o_uart_wr <= 1'b0;
		o_uart_addr <= 32'h0000_0000;
		o_uart_wdata <= 32'h0000_0000;
		o_uart_be_n <= 4'hF;
	end else begin
		frame_q <= i_frame_n;
		o_uart_rd <= 1'b0;
		o_uart_wr <= 1'b0;
		case (state_q)
			S_IDLE: begin
				if (start) begin
					o_uart_addr <= i_ad;
					o_devsel_n <= 1'b0;
					o_tgt_oe <= 1'b1;
					if (i_cbe_n[`CMD_WR_BIT]) begin
						o_trdy_n <= 1'b0;
						o_stop_n <= 1'b0;
						state_q <= S_WDATA;
					end else begin
						o_uart_rd <= 1'b1;
						state_q <= S_RFETCH;
					end
				end
			end
			S_WDATA: begin
				if (!i_irdy_n) begin
					o_uart_wr <= 1'b1;
					o_uart_wdata <= i_ad;
					o_uart_be_n <= i_cbe_n;
					o_devsel_n <= 1'b1;
					o_trdy_n <= 1'b1;
					o_stop_n <= 1'b1;
					state_q <= S_TURN;
				end
			end
			S_RFETCH: begin
				o_ad <= i_uart_rdata;
				o_ad_oe <= 1'b1;
				o_trdy_n <= 1'b0;
				o_stop_n <= 1'b0;
				o_uart_be_n <= i_cbe_n;
				state_q <= S_RDATA;
			end
			S_RDATA: begin
				if (!i_irdy_n) begin
					o_ad_oe <= 1'b0;
					o_devsel_n <= 1'b1;
					o_trdy_n <= 1'b1;
					o_stop_n <= 1'b1;
					state_q <= S_TURN;
				end
			end
			S_TURN: begin
				// Drive high one clock before release, as sustained tri-state needs
				o_tgt_oe <= 1'b0;
				state_q <= S_IDLE;
			end
			default: begin
				state_q <= S_IDLE;
			end
		endcase
	end
end

// ----------------------------------------------------------------------
// Configuration defaults and overrides
// ----------------------------------------------------------------------
wire use_rom;
wire pd_en;
wire wake_en;

assign use_rom = i_eeprom_present & i_eeprom_valid;
assign pd_en = use_rom ? i_eeprom_pd_en : `DEF_PD_EN;
assign wake_en = use_rom ? i_eeprom_wake_en : `DEF_WAKE_EN;

// Identity is registered so it is stable during configuration reads
always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_vendor_id <= `DEF_VENDOR_ID;
		o_device_id <= `DEF_DEVICE_ID;
		o_irq_en <= `DEF_IRQ_EN;
	end else begin
		o_vendor_id <= use_rom ? i_eeprom_vendor_id : `DEF_VENDOR_ID;
		o_device_id <= use_rom ? i_eeprom_device_id : `DEF_DEVICE_ID;
		o_irq_en <= use_rom ? i_eeprom_irq_en : `DEF_IRQ_EN;
	end
end

// ----------------------------------------------------------------------
// Power states, one field per function
// ----------------------------------------------------------------------
wire [1:0] ser_st;
wire [1:0] par_st;
wire [1:0] low_pwr;

assign ser_st = o_pm_state[1:0];
assign par_st = o_pm_state[3:2];
assign low_pwr = {(par_st == `PM_D2) | (par_st == `PM_D3), (ser_st == `PM_D2) | (ser_st == `PM_D3)};

// A request for the unsupported D1 is ignored and the old state kept
always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_pm_state <= {`PM_D0, `PM_D0};
	end else if (i_pm_wr && i_pm_state != `PM_D1) begin
		if (i_pm_fn) begin
			o_pm_state[3:2] <= i_pm_state;
		end else begin
			o_pm_state[1:0] <= i_pm_state;
		end
	end
end

// ----------------------------------------------------------------------
// Wake sources
// ----------------------------------------------------------------------
wire ev_ring;
wire ev_modem;
wire ev_mio;

wake_event_detect #(.WIDTH(NCH)) u_ring (
	.i_clk(i_clk),
	.i_sys_rst(i_sys_rst),
	.i_lines(i_ring_indicator_input),
	.i_arm(ser_st == `PM_D3),
	.o_event(ev_ring)
);

wake_event_detect #(.WIDTH(5 * NCH)) u_modem (
	.i_clk(i_clk),
	.i_sys_rst(i_sys_rst),
	.i_lines({i_ring_indicator_input, i_cts, i_dsr, i_dcd, i_rxd}),
	.i_arm(ser_st == `PM_D2),
	.o_event(ev_modem)
);

wake_event_detect #(.WIDTH(2)) u_mio (
	.i_clk(i_clk),
	.i_sys_rst(i_sys_rst),
	.i_lines(i_multi_purpose_pins),
	.i_arm(low_pwr[`FN_PARALLEL]),
	.o_event(ev_mio)
);

// ----------------------------------------------------------------------
// Event status and wake request
// ----------------------------------------------------------------------
wire [1:0] ev_set;
wire [1:0] pme_drive;

assign ev_set = {ev_mio, ev_ring | ev_modem};
assign pme_drive = o_pme_status & i_pme_en & low_pwr;

// Status is sticky; a new event beats a clear in the same cycle
always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_pme_status <= 2'b00;
		o_pme_n <= 1'b0;
		o_pme_oe <= 1'b0;
	end else begin
		o_pme_status <= (o_pme_status & ~i_pme_clr) | (ev_set & {2{wake_en}});
		o_pme_oe <= |pme_drive;
	end
end

// ----------------------------------------------------------------------
// Driver power-down and port disables
// ----------------------------------------------------------------------
// Honoured only outside D0 so a live function cannot be cut off
always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		o_func_pd <= 2'b00;
		o_uart_disable <= 1'b0;
		o_par_disable <= 1'b0;
	end else begin
		o_func_pd <= i_pd_req & low_pwr & {2{pd_en}};
		o_uart_disable <= i_uart_dis_req & low_pwr[`FN_SERIAL];
		o_par_disable <= i_par_dis_req & low_pwr[`FN_PARALLEL];
	end
end

endmodule

// *** verification/pm_wake_chk_sva.sv ***
// Checker for power-state, wake and serial access timing of the target.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/100ps
module pm_wake_chk (
	// Clock and reset
	input wire i_clk,
	input wire i_sys_rst,
	// Watched ports
	input wire i_pm_wr,
	input wire i_pm_fn,
	input wire [1:0] i_pm_state,
	input wire [1:0] i_pme_clr,
	input wire o_devsel_n,
	input wire o_trdy_n,
	input wire o_stop_n,
	input wire o_tgt_oe,
	input wire o_ad_oe,
	input wire o_uart_rd,
	input wire o_uart_wr,
	input wire [3:0] o_pm_state,
	input wire [1:0] o_pme_status,
	input wire o_pme_oe
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	a_one_wait: assert property (!o_devsel_n && o_trdy_n |=> !o_trdy_n)
		else $error("extra wait state");
	a_rd_done: assert property (o_uart_rd |=> !o_trdy_n)
		else $error("read late");
	a_wr_done: assert property (o_uart_wr |-> !$past(o_trdy_n) && $past(o_devsel_n, 2))
		else $error("write late");
	a_pm_set: assert property (i_pm_wr && i_pm_state != 2'b01 |=>
		($past(i_pm_fn) ? o_pm_state[3:2] : o_pm_state[1:0]) == $past(i_pm_state))
		else $error("state not taken");
	a_d1_ignored: assert property (i_pm_wr && i_pm_state == 2'b01 |=> $stable(o_pm_state))
		else $error("D1 taken");
	a_fn_indep: assert property (i_pm_wr && !i_pm_fn |=> $stable(o_pm_state[3:2]))
		else $error("functions coupled");
	a_wake_state: assert property (o_pme_oe |->
		($past(o_pme_status[0]) && $past(o_pm_state[1:0]) != 2'b00) ||
		($past(o_pme_status[1]) && $past(o_pm_state[3:2]) != 2'b00))
		else $error("wake without cause");
	a_no_d0_wake: assert property ($rose(o_pme_status[0]) |-> $past(o_pm_state[1:0], 2) != 2'b00)
		else $error("wake from D0");
	a_status_hold: assert property (o_pme_status[0] && !i_pme_clr[0] |=> o_pme_status[0])
		else $error("status lost");
	a_stop_with_trdy: assert property (o_stop_n == o_trdy_n)
		else $error("burst not disconnected");
	a_ad_with_trdy: assert property (o_ad_oe |-> !o_trdy_n)
		else $error("read data without trdy");
	a_drive_owned: assert property (!o_devsel_n || o_ad_oe |-> o_tgt_oe)
		else $error("drive without enable");
	// Main scenarios reached
	cover property (o_uart_wr);
	cover property (o_uart_rd);
	cover property ($rose(o_pme_oe));
endmodule
bind pci_power_state_wake_logic pm_wake_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_pm_wr(i_pm_wr), .i_pm_fn(i_pm_fn), .i_pm_state(i_pm_state), .i_pme_clr(i_pme_clr),
	.o_devsel_n(o_devsel_n), .o_trdy_n(o_trdy_n), .o_uart_rd(o_uart_rd), .o_uart_wr(o_uart_wr),
	.o_stop_n(o_stop_n), .o_tgt_oe(o_tgt_oe), .o_ad_oe(o_ad_oe),
	.o_pm_state(o_pm_state), .o_pme_status(o_pme_status), .o_pme_oe(o_pme_oe));

// *** verification/host_model.sv ***
// Bus initiator model: single data phase memory cycles.
// Assumes the target answers with trdy; gives up after eight edges.
`timescale 1ns/100ps
module host_model (
	// Clock and target answer
	input wire i_clk,
	input wire i_trdy_n,
	input wire [31:0] i_rdata,
	// Initiator drive
	output logic o_frame_n,
	output logic o_irdy_n,
	output logic [31:0] o_ad,
	output logic [3:0] o_cbe_n
);
	// Idle bus
	initial begin
		o_frame_n = 1'b1;
		o_irdy_n = 1'b1;
		o_ad = 32'h0000_0000;
		o_cbe_n = 4'hF;
	end
	// Address first, data on the same lines; released lines show junk
	task automatic run(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd, output int lat);
		@(negedge i_clk);
		o_frame_n = 1'b0;
		o_ad = a;
		o_cbe_n = {3'b011, wr};
		@(negedge i_clk);
		o_frame_n = 1'b1;
		o_irdy_n = 1'b0;
		o_ad = wr ? d : ~a;
		o_cbe_n = 4'h0;
		lat = 0;
		do begin
			@(posedge i_clk);
			lat++;
		end while (i_trdy_n !== 1'b0 && lat < 8);
		rd = i_rdata;
		@(negedge i_clk);
		o_irdy_n = 1'b1;
		o_ad = ~o_ad;
		o_cbe_n = 4'hF;
		repeat (2) @(negedge i_clk);
	endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench: wake table, bus timing, states, power-down, ids.
// Assumes the pkg include folder is on the include path.
`timescale 1ns/100ps
module tb;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, pm_wr = 1'b0, pm_fn = 1'b0, dis = 1'b0, ee_ok = 1'b0;
	logic ee_en = 1'b1;
	logic [1:0] pm_st = 2'b00, clr = 2'b00, pd = 2'b00, ri = 2'b00, cts = 2'b00;
	logic [1:0] dsr = 2'b00, dcd = 2'b00, rxd = 2'b00, mpp = 2'b00;
	logic [31:0] rdata = 32'h0000_0000, got, wd_q, wa_q;
	logic e, f;
	logic [1:0] s;
	logic [2:0] src;
	int lat, fail_count = 0, cmp_count = 0, cyc = 0;
	wire frame_n, irdy_n, o_trdy_n, o_uart_wr, o_pme_oe, o_uart_disable;
	wire [31:0] ad, o_ad, o_uart_addr, o_uart_wdata;
	wire [3:0] cbe_n, o_pm_state, o_uart_be_n;
	wire o_pme_n, o_par_disable, o_irq_en;
	wire [1:0] o_pme_status, o_func_pd;
	wire [15:0] o_vendor_id, o_device_id;
	// Rows: expect, function, state, source (ri cts dsr dcd rxd mpp)
	logic [6:0] rows [11] = '{7'b0000000, 7'b0011001, 7'b0011100, 7'b1011000, 7'b1010010,
		7'b1010011, 7'b1010100, 7'b1010001, 7'b1110101, 7'b1111101, 7'b0100101};
	host_model host (.i_clk(i_clk), .i_trdy_n(o_trdy_n), .i_rdata(o_ad), .o_frame_n(frame_n),
		.o_irdy_n(irdy_n), .o_ad(ad), .o_cbe_n(cbe_n));
	pci_power_state_wake_logic uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_frame_n(frame_n),
		.i_irdy_n(irdy_n), .i_ad(ad), .i_cbe_n(cbe_n), .o_ad(o_ad), .o_ad_oe(), .o_devsel_n(),
		.o_trdy_n(o_trdy_n), .o_stop_n(), .o_tgt_oe(), .o_uart_rd(), .o_uart_wr(o_uart_wr),
		.o_uart_addr(o_uart_addr), .o_uart_wdata(o_uart_wdata), .o_uart_be_n(o_uart_be_n),
		.i_uart_rdata(rdata),
		.i_pm_wr(pm_wr), .i_pm_fn(pm_fn), .i_pm_state(pm_st), .i_pme_en(2'b11), .i_pme_clr(clr),
		.o_pm_state(o_pm_state), .o_pme_status(o_pme_status), .i_ring_indicator_input(ri), .i_cts(cts),
		.i_dsr(dsr), .i_dcd(dcd), .i_rxd(rxd), .i_multi_purpose_pins(mpp), .o_pme_n(o_pme_n),
		.o_pme_oe(o_pme_oe), .i_pd_req(pd), .i_uart_dis_req(dis), .i_par_dis_req(dis), .o_func_pd(o_func_pd),
		.o_uart_disable(o_uart_disable), .o_par_disable(o_par_disable), .i_eeprom_present(ee_ok),
		.i_eeprom_valid(ee_ok), .i_eeprom_vendor_id(16'hBEEF), .i_eeprom_device_id(rdata[15:0]),
		.i_eeprom_irq_en(ee_en), .i_eeprom_pd_en(ee_en), .i_eeprom_wake_en(ee_en),
		.o_vendor_id(o_vendor_id), .o_device_id(o_device_id), .o_irq_en(o_irq_en));
	// Clock, write capture and hang guard
	initial forever #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		if (o_uart_wr === 1'b1) begin
			wd_q <= o_uart_wdata;
			wa_q <= o_uart_addr;
		end
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic pm_set(input logic fn, input logic [1:0] st);
		@(negedge i_clk);
		{pm_wr, pm_fn, pm_st} = {1'b1, fn, st};
		@(negedge i_clk);
		pm_wr = 1'b0;
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (16) @(negedge i_clk);
		i_sys_rst = 1'b0;
		chk("vendor", 32'h0000_1234, o_vendor_id);
		chk("state", 32'h0, o_pm_state);
		foreach (rows[k]) begin
			{e, f, s, src} = rows[k];
			pm_set(f, s);
			case (src)
				3'd0: ri[1] = ~ri[1];
				3'd1: cts[1] = ~cts[1];
				3'd2: dsr[0] = ~dsr[0];
				3'd3: dcd[1] = ~dcd[1];
				3'd4: rxd[0] = ~rxd[0];
				default: mpp[1] = ~mpp[1];
			endcase
			repeat (6) @(negedge i_clk);
			chk("pme_oe", e, o_pme_oe);
			chk("status", e, o_pme_status[f]);
			clr = 2'b11;
			pm_set(f, 2'b00);
			clr = 2'b00;
			@(negedge i_clk);
			chk("pme_off", 0, o_pme_oe);
			$display("wake row %0d done", k);
		end
		rdata = 32'hC3A5_7001;
		host.run(1'b0, 32'h0000_0010, 32'h0, got, lat);
		chk("rd_data", rdata, got);
		chk("rd_late", 1, lat <= 3);
		host.run(1'b1, 32'h0000_0024, 32'h5A5A_1234, got, lat);
		chk("wr_data", 32'h5A5A_1234, wd_q);
		chk("wr_addr", 32'h0000_0024, wa_q);
		chk("wr_be", 32'h0, o_uart_be_n);
		chk("wr_late", 1, lat <= 2);
		host.run(1'b0, 32'h0000_0100, 32'h0, got, lat);
		chk("refused", 8, lat);
		$display("bus test done");
		pm_set(0, 2'b10);
		pm_set(0, 2'b01);
		pm_set(1, 2'b11);
		chk("d1_ign", 32'hE, o_pm_state);
		{pd, dis} = 3'b111;
		repeat (2) @(negedge i_clk);
		chk("func_pd", 32'h3, o_func_pd);
		chk("uart_dis", 1, o_uart_disable);
		chk("par_dis", 1, o_par_disable);
		pm_set(0, 2'b00);
		pm_set(1, 2'b00);
		@(negedge i_clk);
		chk("pd_d0", 32'h0, o_func_pd);
		ee_ok = 1'b1;
		repeat (2) @(negedge i_clk);
		chk("ee_vid", 32'h0000_BEEF, o_vendor_id);
		chk("ee_did", 32'h0000_7001, o_device_id);
		chk("ee_irq_on", 1, o_irq_en);
		// Memory clears its enables: no power-down, no wake, no interrupts
		ee_en = 1'b0;
		pm_set(0, 2'b10);
		rxd[0] = ~rxd[0];
		repeat (4) @(negedge i_clk);
		chk("ee_irq_off", 0, o_irq_en);
		chk("ee_pd_off", 32'h0, o_func_pd);
		chk("ee_wake_off", 0, o_pme_status[0]);
		pm_set(0, 2'b00);
		ee_en = 1'b1;
		ee_ok = 1'b0;
		repeat (2) @(negedge i_clk);
		chk("def_did", 32'h0000_0001, o_device_id);
		$display("state and id test done");
		// Reset in mid-run while a wake request stands
		pm_set(0, 2'b11);
		ri[0] = ~ri[0];
		repeat (4) @(negedge i_clk);
		chk("pre_rst", 1, o_pme_oe);
		i_sys_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_sys_rst = 1'b0;
		chk("rst_pme", 0, o_pme_oe);
		chk("rst_pme_n", 0, o_pme_n);
		chk("rst_status", 32'h0, o_pme_status);
		chk("rst_state", 32'h0, o_pm_state);
		chk("rst_pd", 32'h0, o_func_pd);
		chk("rst_irq", 1, o_irq_en);
		$display("reset test done");
		final_report();
	end
endmodule
